// [hw/pwmirq_pkg.sv]
// Purpose: Constants and types for the PWM interrupt and output stage
// Assumes: AXI4-Lite register bus, 32-bit data, one word per register
// Notes:   Printed offsets are not all multiples of four, so they are indices
package pwmirq_pkg;

  localparam int unsigned NCH          = 4;
  localparam int unsigned CW           = 16;

  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_TIMER_CTRL  = 16'hEC00;
  localparam logic [15:0] IDX_MODE_CTRL   = 16'hEC02;
  localparam logic [15:0] IDX_POLARITY    = 16'hEC04;
  localparam logic [15:0] IDX_MOD_IRQ     = 16'hF196;
  localparam logic [15:0] IDX_EVT_STATUS  = 16'hF200;
  localparam logic [15:0] IDX_EVT_MASK    = 16'hF201;
  localparam logic [15:0] IDX_CNT_BASE    = 16'hEC10;
  localparam logic [15:0] IDX_WID_BASE    = 16'hEC30;

  localparam int unsigned ADDR_W        = 18;

  // Field positions
  localparam int unsigned POS_RUN       = 0;
  localparam int unsigned POS_CIE       = 8;
  localparam int unsigned POS_CIR       = 12;
  localparam int unsigned POS_OEN       = 0;
  localparam int unsigned POS_MIR       = 7;
  localparam int unsigned POS_MIE       = 6;

  // Reset values
  localparam logic [15:0] RST_TIMER_CTRL = 16'h0000;
  localparam logic [15:0] RST_MODE_CTRL  = 16'h0000;
  localparam logic [15:0] RST_POLARITY   = 16'h0000;
  localparam logic [7:0]  RST_MOD_IRQ    = 8'h00;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [NCH-1:0]         reload;
    logic [NCH*CW-1:0]      count;
    logic [NCH*CW-1:0]      width;
  } pwmirq_core_s;

  typedef struct packed {
    logic [NCH-1:0]         run;
    logic [NCH-1:0]         cnt_wr;
    logic [CW-1:0]          cnt_wdata;
  } pwmirq_ctl_s;

endpackage : pwmirq_pkg

// [hw/pwmirq_top.sv]
// Purpose: PWM interrupt request and output stage with AXI4-Lite registers
// Assumes: Counter core on the same clock; isr_enter is a one-cycle pulse
// Notes:   Counter core supplies reload pulses, counters and width latches
// Function
// [RQ1] Four channel request flags, any may raise one module interrupt
// [RQ2] Channel flag set when its shadow registers reload
// [RQ3] Enabled channel request sets module flag if module enable is one
// [RQ4] Service entry leaves channel flags; software clears them
// [RQ5] Service entry clears module flag regardless of pending channels
// [RQ6] New enabled request during service sets module flag again
// [RQ7] Output reaches pin only when its channel output enable is set
// [RQ8] Output XORed with channel polarity bit before the pin
// [RQ9] Clearing run bit stops counter and holds output level
// [RQ10] Raw output high while counter at or above width shadow latch
// [RQ11] Software stops counter before forcing output by counter write
// [RQ12] Control word bits 15:12 request flags, 11:8 interrupt enables
// [RQ13] Mode word bits 3:0 output enables; disabled channel still interrupts
// [RQ14] Disabled channel drives inactive low before polarity XOR
//
// Chosen here: the AXI4-Lite register port.
module pwmirq_top (
  core_clk,
  nrst,
  core_i,
  isr_enter,
  ctl_o,
  chan_output_pins,
  module_irq_request,
  evt_irq,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready
);
  import pwmirq_pkg::*;

  input  wire logic                           core_clk;
  input  wire logic                           nrst;
  input  wire pwmirq_pkg::pwmirq_core_s       core_i;
  input  wire logic                           isr_enter;
  output logic      [pwmirq_pkg::NCH-1:0]     chan_output_pins;
  output pwmirq_pkg::pwmirq_ctl_s             ctl_o;
  output logic                                module_irq_request;
  output logic                                evt_irq;
  input  wire logic [pwmirq_pkg::ADDR_W-1:0]  s_axi_awaddr;
  input  wire logic                           s_axi_awvalid;
  output logic                                s_axi_awready;
  input  wire logic [31:0]                    s_axi_wdata;
  input  wire logic [3:0]                     s_axi_wstrb;
  input  wire logic                           s_axi_wvalid;
  output logic                                s_axi_wready;
  output logic      [1:0]                     s_axi_bresp;
  output logic                                s_axi_bvalid;
  input  wire logic                           s_axi_bready;
  input  wire logic [pwmirq_pkg::ADDR_W-1:0]  s_axi_araddr;
  input  wire logic                           s_axi_arvalid;
  output logic                                s_axi_arready;
  output logic      [31:0]                    s_axi_rdata;
  output logic      [1:0]                     s_axi_rresp;
  output logic                                s_axi_rvalid;
  input  wire logic                           s_axi_rready;

  function automatic logic [15:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[17:2];
  endfunction : word_idx

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Register state
  logic [15:0]     tctl_q, tctl_d;
  logic [15:0]     mctl_q, mctl_d;
  logic [15:0]     pol_q, pol_d;
  logic [7:0]      mirq_q, mirq_d;
  logic [1:0]      est_q, est_d;
  logic [1:0]      emsk_q, emsk_d;
  logic [NCH-1:0]  pin_q, pin_d;
  pwmirq_ctl_s     ctl_q, ctl_d;

  // Bus state
  logic [ADDR_W-1:0] awa_q, awa_d;
  logic              awh_q, awh_d;
  logic [31:0]       wd_q, wd_d;
  logic [3:0]        ws_q, ws_d;
  logic              wh_q, wh_d;
  logic              bv_q, bv_d;
  logic [1:0]        br_q, br_d;
  logic              rv_q, rv_d;
  logic [31:0]       rd_q, rd_d;
  logic [1:0]        rr_q, rr_d;
  logic              awrdy_q, awrdy_d;
  logic              wrdy_q, wrdy_d;
  logic              arrdy_q, arrdy_d;

  logic [NCH-1:0] raw;
  logic [NCH-1:0] new_req;
  logic           do_wr;
  logic [15:0]    widx;
  logic [15:0]    ridx;

  always_comb begin
    do_wr = awh_q && wh_q && !bv_q;
    widx  = word_idx(awa_q);
    ridx  = word_idx(s_axi_araddr);
  end

  always_comb begin
    awh_d = awh_q;
    awa_d = awa_q;
    wh_d  = wh_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_awvalid && awrdy_q) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_q) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    if (do_wr) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = RESP_OKAY;
      if (!(widx == IDX_TIMER_CTRL || widx == IDX_MODE_CTRL || widx == IDX_POLARITY ||
            widx == IDX_MOD_IRQ || widx == IDX_EVT_STATUS || widx == IDX_EVT_MASK ||
            (widx >= IDX_CNT_BASE && widx < IDX_CNT_BASE + 16'(NCH)))) begin
        br_d = RESP_SLVERR;
      end
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (s_axi_arvalid && arrdy_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      rd_d = 32'h0000_0000;
      if (ridx == IDX_TIMER_CTRL) begin
        rd_d = {16'h0000, tctl_q};
      end else if (ridx == IDX_MODE_CTRL) begin
        rd_d = {16'h0000, mctl_q};
      end else if (ridx == IDX_POLARITY) begin
        rd_d = {16'h0000, pol_q};
      end else if (ridx == IDX_MOD_IRQ) begin
        rd_d = {24'h00_0000, mirq_q};
      end else if (ridx == IDX_EVT_STATUS) begin
        rd_d = {30'h0000_0000, est_q};
      end else if (ridx == IDX_EVT_MASK) begin
        rd_d = {30'h0000_0000, emsk_q};
      end else if (ridx >= IDX_CNT_BASE && ridx < IDX_CNT_BASE + 16'(NCH)) begin
        rd_d = {16'h0000, core_i.count[CW*ridx[1:0] +: CW]};
      end else if (ridx >= IDX_WID_BASE && ridx < IDX_WID_BASE + 16'(NCH)) begin
        rd_d = {16'h0000, core_i.width[CW*ridx[1:0] +: CW]};
      end else begin
        rr_d = RESP_SLVERR;
      end
    end
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    awrdy_d = !awh_d;
    wrdy_d  = !wh_d;
    arrdy_d = !rv_d;
  end

  // Channel and module interrupt logic
  always_comb begin
    tctl_d = tctl_q;
    mctl_d = mctl_q;
    pol_d  = pol_q;
    mirq_d = mirq_q;
    est_d  = est_q;
    emsk_d = emsk_q;
    ctl_d  = ctl_q;
    ctl_d.cnt_wr = '0;
    if (do_wr) begin
      if (widx == IDX_TIMER_CTRL) begin
        tctl_d = merge16(tctl_q, wd_q, ws_q);
      end
      if (widx == IDX_MODE_CTRL) begin
        mctl_d = merge16(mctl_q, wd_q, ws_q) & 16'hD0FF;
      end
      if (widx == IDX_POLARITY) begin
        pol_d = merge16(pol_q, wd_q, ws_q) & 16'h000F;
      end
      if (widx == IDX_MOD_IRQ && ws_q[0]) begin
        mirq_d = wd_q[7:0];
      end
      if (widx == IDX_EVT_STATUS && ws_q[0]) begin
        est_d = est_q & ~wd_q[1:0];
      end
      if (widx == IDX_EVT_MASK && ws_q[0]) begin
        emsk_d = wd_q[1:0];
      end
      // [RQ11] Counter write
      if (widx >= IDX_CNT_BASE && widx < IDX_CNT_BASE + 16'(NCH)) begin
        ctl_d.cnt_wr[widx[1:0]] = 1'b1;
        ctl_d.cnt_wdata = merge16(core_i.count[CW*widx[1:0] +: CW], wd_q, ws_q);
      end
    end
    // [RQ2] Reload sets flag
    // [RQ4] Set wins clear
    // [RQ12] Flag and enable fields
    new_req = core_i.reload;
    tctl_d[POS_CIR +: NCH] = tctl_d[POS_CIR +: NCH] | new_req;
    // [RQ5] Service entry clears
    if (isr_enter) begin
      mirq_d[POS_MIR] = 1'b0;
    end
    // [RQ1] Any enabled channel reload request raises module
    // [RQ3] Enabled request propagates
    // [RQ6] Sets again
    if (|(new_req & tctl_q[POS_CIE +: NCH]) && mirq_q[POS_MIE]) begin
      mirq_d[POS_MIR] = 1'b1;
      est_d[0] = 1'b1;
    end
    if (isr_enter) begin
      est_d[1] = 1'b1;
    end
    // [RQ9] Run bit to counter
    ctl_d.run = tctl_q[POS_RUN +: NCH];
  end

  // Output stage
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      // [RQ10] Compare counter width
      raw[i] = core_i.count[CW*i +: CW] >= core_i.width[CW*i +: CW];
      // [RQ7] Gate by enable
      // [RQ13] Enable bits 3:0
      // [RQ14] Inactive low
      // [RQ8] Polarity XOR
      pin_d[i] = (raw[i] & mctl_q[POS_OEN + i]) ^ pol_q[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tctl_q <= RST_TIMER_CTRL;
      mctl_q <= RST_MODE_CTRL;
      pol_q  <= RST_POLARITY;
      mirq_q <= RST_MOD_IRQ;
      est_q  <= 2'h0;
      emsk_q <= 2'h0;
      pin_q  <= '0;
      ctl_q  <= '0;
      awh_q  <= 1'b0;
      awa_q  <= '0;
      wh_q   <= 1'b0;
      wd_q   <= 32'h0000_0000;
      ws_q   <= 4'h0;
      bv_q   <= 1'b0;
      br_q   <= 2'h0;
      rv_q   <= 1'b0;
      rd_q   <= 32'h0000_0000;
      rr_q   <= 2'h0;
      awrdy_q <= 1'b0;
      wrdy_q  <= 1'b0;
      arrdy_q <= 1'b0;
    end else begin
      tctl_q <= tctl_d;
      mctl_q <= mctl_d;
      pol_q  <= pol_d;
      mirq_q <= mirq_d;
      est_q  <= est_d;
      emsk_q <= emsk_d;
      pin_q  <= pin_d;
      ctl_q  <= ctl_d;
      awh_q  <= awh_d;
      awa_q  <= awa_d;
      wh_q   <= wh_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rd_q   <= rd_d;
      rr_q   <= rr_d;
      awrdy_q <= awrdy_d;
      wrdy_q  <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  logic irq_q;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(est_d & emsk_d);
    end
  end

  // [RQ9] Held output follows frozen counter
  always_comb begin
    chan_output_pins   = pin_q;
    ctl_o              = ctl_q;
    module_irq_request = mirq_q[POS_MIR];
    evt_irq            = irq_q;
    s_axi_awready      = awrdy_q;
    s_axi_wready       = wrdy_q;
    s_axi_bvalid       = bv_q;
    s_axi_bresp        = br_q;
    s_axi_arready      = arrdy_q;
    s_axi_rvalid       = rv_q;
    s_axi_rdata        = rd_q;
    s_axi_rresp        = rr_q;
  end

endmodule : pwmirq_top

// [verif/pwmirq_properties.sv]
// Purpose: Port properties of the PWM interrupt and output stage
// Assumes: Bound to pwmirq_top
// Notes:   Register writes land by the response
module pwmirq_properties
  import pwmirq_pkg::*;
(
  input wire logic                     core_clk,
  input wire logic                     nrst,
  input wire pwmirq_pkg::pwmirq_core_s core_i,
  input wire logic                     isr_enter,
  input wire pwmirq_pkg::pwmirq_ctl_s  ctl_o,
  input wire logic [3:0]               chan_output_pins,
  input wire logic                     module_irq_request,
  input wire logic                     evt_irq,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  AST_MIR_CLR: assert property (isr_enter && core_i.reload == '0 && !s_axi_wvalid
    && !$past(s_axi_wvalid) && !s_axi_bvalid |=> !module_irq_request) else $error("flag kept");
  AST_MIR_SRC: assert property ($rose(module_irq_request) |-> $past(|core_i.reload)
    || $past(s_axi_wvalid) || s_axi_bvalid) else $error("flag without cause");
  AST_EVT_SRC: assert property ($rose(evt_irq) |-> $rose(module_irq_request)
    || $past(|core_i.reload) || $past(isr_enter) || $past(s_axi_wvalid) || s_axi_bvalid)
    else $error("irq no cause");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  AST_AR_FULL: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read overrun");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("double response");
  AST_CNT_WR: assert property (|ctl_o.cnt_wr |-> $onehot(ctl_o.cnt_wr)
    ##1 ctl_o.cnt_wr == '0) else $error("bad load strobe");
  AST_PIN_HOLD: assert property ($stable(core_i.count) && $stable(core_i.width)
    && !s_axi_wvalid && !$past(s_axi_wvalid) && !s_axi_bvalid && !$past(s_axi_bvalid)
    |=> $stable(chan_output_pins)) else $error("pin moved");
  cover property ($rose(module_irq_request));
  cover property (isr_enter && module_irq_request);
  cover property (|ctl_o.cnt_wr);
endmodule : pwmirq_properties

// [verif/test_pwmirq_top.sv]
// Purpose: Self-checking bench for the PWM interrupt and output stage
// Assumes: Byte address is four times the register index
// Notes:   Pin patterns random from a fixed seed
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module test_pwmirq_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwmirq_pkg::*;
  logic core_clk = 0, nrst = 0, isr_enter = 0;
  pwmirq_core_s core_i = '0;
  pwmirq_ctl_s ctl_o;
  logic [3:0] chan_output_pins, s_axi_wstrb = '1, oen, pol, ex;
  logic module_irq_request, evt_irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, s_axi_wdata = '0, q;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [19:0] seen = '0;
  logic [15:0] c, w;
  logic [15:0] ridx [5] = '{IDX_TIMER_CTRL, IDX_MODE_CTRL, IDX_POLARITY, IDX_MOD_IRQ, 16'h0100};
  int failures = 0, cmp_count = 0, seed = 32'h8df46eb6, ie, fl, mir, mie;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (|ctl_o.cnt_wr) seen <= {ctl_o.cnt_wr, ctl_o.cnt_wdata};
  pwmirq_top DUT (.*);
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
    int n;
    logic a;
    logic b;
    @(posedge core_clk);
    a = 1;
    b = wr;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_araddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (a && (wr ? s_axi_awready : s_axi_arready)) begin
        a = 0;
        s_axi_awvalid <= 0;
        s_axi_arvalid <= 0;
      end
      if (b && s_axi_wready) begin
        b = 0;
        s_axi_wvalid <= 0;
      end
      if (wr ? s_axi_bvalid : s_axi_rvalid) break;
    end
    q = s_axi_rdata;
    r = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 0;
    s_axi_rready <= 0;
    if (n == 50) begin
      failures++;
      report_and_stop();
    end
  endtask : bus
  task automatic pulse(input logic [3:0] rl, input logic isr);
    @(posedge core_clk);
    core_i.reload <= rl;
    isr_enter <= isr;
    @(posedge core_clk);
    core_i.reload <= '0;
    isr_enter <= 0;
    repeat (2) @(posedge core_clk);
    fl |= rl;
    if (isr) mir = 0;
    if (mie != 0 && (rl & ie) != 0) mir = 1;
  endtask : pulse
  initial begin
    repeat (6) @(posedge core_clk);
    nrst <= 1;
    foreach (ridx[i]) begin
      bus(0, ridx[i], 0);
      `CHK(q, 32'h0)
      `CHK(r, i == 4 ? RESP_SLVERR : RESP_OKAY)
    end
    for (int k = 0; k < 8; k++) begin
      oen = $random(seed);
      pol = $random(seed);
      c = $random(seed);
      w = k[0] ? $random(seed) : c;
      bus(1, IDX_MODE_CTRL, {28'h0, oen});
      bus(1, IDX_POLARITY, {28'h0, pol});
      @(posedge core_clk);
      for (int i = 0; i < NCH; i++) begin
        core_i.count[16*i +: 16] <= c;
        core_i.width[16*i +: 16] <= w ^ 16'(i);
        ex[i] = ((c >= (w ^ 16'(i))) & oen[i]) ^ pol[i];
      end
      repeat (2) @(posedge core_clk);
      `CHK(chan_output_pins, ex)
    end
    bus(1, IDX_MODE_CTRL, 32'hFFFF);
    bus(0, IDX_MODE_CTRL, 0);
    `CHK(q, 32'h0000_D0FF)
    bus(1, IDX_MODE_CTRL, 0);
    repeat (2) @(posedge core_clk);
    `CHK(chan_output_pins, pol)
    bus(1, IDX_WID_BASE, 32'h1);
    `CHK(r, RESP_SLVERR)
    bus(1, IDX_MOD_IRQ, 32'h40);
    bus(1, IDX_EVT_MASK, 32'h1);
    mie = 1;
    for (int ch = 0; ch < NCH; ch++) begin
      ie = 1 << ch;
      fl = 0;
      bus(1, IDX_TIMER_CTRL, {20'h0, 4'(ie), 4'h0, ~4'(ie)});
      pulse(4'hF & ~4'(ie), 1);
      `CHK(module_irq_request, 1'(mir))
      `CHK(ctl_o.run, ~4'(ie))
      bus(0, IDX_TIMER_CTRL, 0);
      `CHK(q[15:12], 4'(fl))
      pulse(4'(ie), 0);
      `CHK(module_irq_request, 1'(mir))
      `CHK(evt_irq, 1'b1)
      `CHK(chan_output_pins, pol)
      pulse(0, 1);
      `CHK(module_irq_request, 1'(mir))
      bus(0, IDX_TIMER_CTRL, 0);
      `CHK(q[15:12], 4'hF)
      pulse(4'(ie), 0);
      `CHK(module_irq_request, 1'(mir))
      bus(1, IDX_EVT_STATUS, 32'h3);
      `CHK(evt_irq, 1'b0)
      c = $random(seed);
      bus(1, IDX_CNT_BASE + 16'(ch), {16'h0, c});
      repeat (2) @(posedge core_clk);
      `CHK(seen, {4'(ie), c})
    end
    pulse(4'(ie), 1);
    `CHK(module_irq_request, 1'(mir))
    bus(1, IDX_MOD_IRQ, 0);
    mie = 0;
    pulse(0, 1);
    pulse(4'(ie), 0);
    `CHK(module_irq_request, 1'b0)
    report_and_stop();
  end
endmodule : test_pwmirq_top
bind pwmirq_top pwmirq_properties u_props (.*);
